//--- bench/ptp_far_model.sv
// motor, home switch and encoder seen by the positioner
`timescale 1ns/1ps
`default_nettype none
module ptp_far_model (
  input wire logic clk_sys,
  input wire ptp_pkg::ptp_drive_type drive,
  output logic forward_limit_input_n,
  output logic reverse_limit_input_n,
  output logic encoder_index,
  output logic motion_settled
);
  import ptp_pkg::*;
  int pos = 20;
  int cnt = 0;
  logic signed [31:0] last = '0;
  wire logic moving = drive.velocity_mode && !drive.stop_request;
  always @(posedge clk_sys) begin
    if (moving) pos <= drive.reverse_dir ? pos - 1 : pos + 1;
    last <= drive.target_position;
    cnt <= (moving || drive.target_position != last) ? 3 : (cnt > 0 ? cnt - 1 : 0);
  end
  // home switch on the reverse side, start input idle
  assign reverse_limit_input_n = pos > 0;
  assign forward_limit_input_n = 1'b1;
  // index every 8 counts in forward motion only, also while still on the switch
  assign encoder_index = moving && !drive.reverse_dir && pos % 8 == 0;
  assign motion_settled = cnt == 0 && drive.target_position == last && !moving;
endmodule // ptp_far_model
`default_nettype wire

//--- bench/ptp_monitor.sv
// port-level checker for the point-table positioner
`timescale 1ns/1ps
`default_nettype none
module ptp_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire ptp_pkg::ptp_apb_req_type apb_req,
  input wire ptp_pkg::ptp_apb_rsp_type apb_rsp,
  input wire logic mode_switch_input_n,
  input wire logic encoder_index,
  input wire logic servo_on,
  input wire logic overtravel,
  input wire ptp_pkg::ptp_drive_type drive
);
  import ptp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [31:0] ctrl;
  wire logic pm = ctrl[3:0] == CMODE_POINT;
  wire logic wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  wire logic mapped = apb_req.paddr[11:8] == 4'h1 ||
                      (apb_req.paddr <= ADDR_PULSE && apb_req.paddr[1:0] == 2'h0);
  // shadow of the control word, taken as the write lands
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ctrl <= '0;
    else if (wr && apb_req.paddr == ADDR_CTRL) ctrl <= apb_req.pwdata;
  end
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_access |=> apb_rsp.pready)
    else $error("answer not one cycle after access");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_err_decode: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
    else $error("error flag does not match address");
  a_clamp_low: assert property ((!pm && !mode_switch_input_n)[*2] |-> drive.motor_clamp)
    else $error("no clamp while switch low");
  a_clamp_high: assert property ((!pm && mode_switch_input_n)[*2] |-> !drive.motor_clamp)
    else $error("clamp while switch high");
  a_hold_count: assert property ((!pm && drive.motor_clamp)[*3] |-> $stable(drive.target_position))
    else $error("count moved while inhibited");
  a_no_clamp_pt: assert property (pm[*2] |-> !drive.motor_clamp)
    else $error("clamp in point mode");
  a_zero_index: assert property ($rose(drive.coord_zero) |-> $past(encoder_index) || $past(encoder_index, 2))
    else $error("zero without index pulse");
  a_zero_target: assert property (drive.coord_zero |-> ##[0:1] drive.target_position == 0)
    else $error("target not zero at reference");
  a_coord_pulse: assert property (drive.coord_zero |=> !drive.coord_zero)
    else $error("reference pulse too long");
  a_search_nocl: assert property (drive.velocity_mode |-> !drive.current_limit_enable)
    else $error("current limit during search");
  a_clear_soff: assert property ((!servo_on && ctrl[10:9] == ECLR_SERVO_OFF)[*3] |-> drive.error_clear)
    else $error("no clear at servo off");
  a_clear_never: assert property ((ctrl[10:9] == 2'h1)[*3] |-> !drive.error_clear)
    else $error("clear under never policy");
  a_clear_ot: assert property ((overtravel && ctrl[10:9] == ECLR_BOTH)[*3] |-> drive.error_clear)
    else $error("no clear at overtravel");
endmodule // ptp_monitor
bind ptp_positioner ptp_monitor i_mon (.clk_sys(clk_sys), .nrst(nrst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .mode_switch_input_n(mode_switch_input_n), .encoder_index(encoder_index),
  .servo_on(servo_on), .overtravel(overtravel), .drive(drive));
`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the point-table positioner
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ptp_pkg::*;
  logic clk_sys, nrst, ref_pulse, ref_dir, msw_n, servo_on, overtravel, err;
  logic fl_n, rl_n, idx_pulse, settled;
  logic [31:0] rd;
  ptp_apb_req_type req;
  ptp_apb_rsp_type rsp;
  ptp_drive_type drv;
  int num_errors = 0;
  int samples_checked = 0;
  int n;
  ptp_positioner #(.DWELL_CYCLES(4)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req),
    .apb_rsp(rsp), .ref_pulse(ref_pulse), .ref_dir(ref_dir), .mode_switch_input_n(msw_n),
    .forward_limit_input_n(fl_n), .reverse_limit_input_n(rl_n), .encoder_index(idx_pulse),
    .servo_on(servo_on), .overtravel(overtravel), .motion_settled(settled), .drive(drv));
  ptp_far_model i_far (.clk_sys(clk_sys), .drive(drv), .forward_limit_input_n(fl_n),
    .reverse_limit_input_n(rl_n), .encoder_index(idx_pulse), .motion_settled(settled));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    @(posedge clk_sys);
    while (rsp.pready !== 1'b1) @(posedge clk_sys);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic pt(input logic [3:0] i, input logic [31:0] off, input logic [31:0] spd,
                    input logic [31:0] flt);
    apb(1'b1, ADDR_PT_BASE | {4'h0, i, 4'h0}, off);
    apb(1'b1, ADDR_PT_BASE | {4'h0, i, 4'h4}, spd);
    apb(1'b1, ADDR_PT_BASE | {4'h0, i, 4'h8}, flt);
    apb(1'b1, ADDR_PT_BASE | {4'h0, i, 4'hc}, 32'h2);
  endtask
  task automatic pulses(input int k, input logic dir);
    ref_dir <= dir;
    repeat (k) begin
      ref_pulse <= 1'b1;
      @(posedge clk_sys);
      ref_pulse <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task automatic home();
    for (n = 0; n < 500 && drv.velocity_mode !== 1'b1; n++) @(posedge clk_sys);
    check(drv.reverse_dir, 1);
    check(drv.speed_rpm, 3000);
    for (n = 0; n < 500 && drv.stop_request !== 1'b1; n++) @(posedge clk_sys);
    check(drv.velocity_mode, 0);
    for (n = 0; n < 500 && !(drv.velocity_mode === 1'b1 && drv.reverse_dir === 1'b0); n++)
      @(posedge clk_sys);
    check(drv.speed_rpm, 10);
    for (n = 0; n < 500 && drv.coord_zero !== 1'b1; n++) @(posedge clk_sys);
    check(n < 500, 1);
    check(rl_n, 1);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic step(input logic tog, input logic [31:0] old, input logic [31:0] exp,
                      input logic [3:0] idx);
    repeat (10) @(posedge clk_sys);
    if (tog) msw_n <= ~msw_n;
    for (n = 0; n < 500 && drv.target_position === old; n++) @(posedge clk_sys);
    check(drv.target_position, exp);
    check(drv.point_index, idx);
  endtask
  task automatic s_regs();
    apb(1'b0, ADDR_SPEED, 0);
    check(rd, 32'h001e05dc);
    apb(1'b1, ADDR_SPEED, 32'h00ff0fa0);
    apb(1'b0, ADDR_SPEED, 0);
    check(rd, 32'h00c80bb8);
    apb(1'b1, ADDR_SPEED, 32'h000a0bb8);
    apb(1'b1, ADDR_PT_BASE | 12'h020, 32'h2ee0d8f0);
    apb(1'b0, ADDR_PT_BASE | 12'h020, 0);
    check(rd, 32'h270fd8f1);
    apb(1'b0, 12'h020, 0);
    check(err, 1);
  endtask
  task automatic s_inhibit();
    apb(1'b1, ADDR_CTRL, 0);
    pulses(5, 1'b0);
    msw_n <= 1'b0;
    pulses(3, 1'b0);
    check(drv.motor_clamp, 1);
    msw_n <= 1'b1;
    pulses(2, 1'b1);
    repeat (3) @(posedge clk_sys);
    apb(1'b0, ADDR_PULSE, 0);
    check(rd, 3);
    check(drv.target_position, 3);
  endtask
  task automatic s_clear();
    servo_on <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(drv.error_clear, 1);
    apb(1'b1, ADDR_CTRL, 32'h200);
    repeat (3) @(posedge clk_sys);
    check(drv.error_clear, 0);
    apb(1'b1, ADDR_CTRL, 32'h400);
    servo_on <= 1'b1;
    overtravel <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check(drv.error_clear, 1);
    overtravel <= 1'b0;
    apb(1'b1, ADDR_CTRL, 0);
  endtask
  task automatic s_abs();
    pt(4'h0, 32'hff9c0064, 100, 7);
    pt(4'h1, 32'h270fffff, 200, 9);
    apb(1'b1, ADDR_CTRL, 32'h0011083c);
    home();
    step(1'b0, 0, 999900, 4'h0);
    check(drv.speed_rpm, 100);
    check(drv.reference_filter_time, 7);
    step(1'b0, 999900, 32'hffffffff, 4'h1);
    repeat (100) @(posedge clk_sys);
    check(drv.target_position, 32'hffffffff);
    check(drv.stop_method_field, 1);
    apb(1'b0, ADDR_POS, 0);
    check(rd, 32'hffffffff);
    apb(1'b0, ADDR_STATUS, 0);
    check(rd[15], 1);
    check(rd[3:0], ST_DONE);
  endtask
  task automatic s_rel();
    apb(1'b1, ADDR_CTRL, 0);
    apb(1'b1, ADDR_CTRL, 32'h0011008c);
    home();
    step(1'b1, 0, 999900, 4'h0);
    step(1'b1, 999900, 999899, 4'h1);
    step(1'b1, 999899, 1999799, 4'h0);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    ref_pulse = 1'b0;
    ref_dir = 1'b0;
    msw_n = 1'b1;
    servo_on = 1'b1;
    overtravel = 1'b0;
    req = '0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    s_regs();
    s_inhibit();
    s_clear();
    s_abs();
    s_rel();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire

//--- hdl/ptp_pkg.sv
// constants, register map and carrier types of the point-table positioner
package ptp_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_SPEED = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_POS = 12'h00c;
  localparam logic [11:0] ADDR_PULSE = 12'h010;
  localparam logic [11:0] ADDR_PT_BASE = 12'h100;
  localparam logic [11:0] ADDR_PT_MASK = 12'hf00;
  localparam int PT_IDX_LSB = 4;
  localparam int PT_WORD_LSB = 2;
  localparam logic [1:0] PT_WORD_OFFSET = 2'h0;
  localparam logic [1:0] PT_WORD_SPEED = 2'h1;
  localparam logic [1:0] PT_WORD_FILTER = 2'h2;
  localparam logic [1:0] PT_WORD_DWELL = 2'h3;
  localparam int SPEED_CREEP_LSB = 16;

  // control mode codes
  localparam logic [3:0] CMODE_POINT = 4'hc;

  // error clear policies
  localparam logic [1:0] ECLR_SERVO_OFF = 2'h0;
  localparam logic [1:0] ECLR_BOTH = 2'h2;

  // speed limits and resets, rpm
  localparam logic [11:0] SEARCH_MAX = 12'hbb8;
  localparam logic [11:0] SEARCH_RESET = 12'h5dc;
  localparam logic [7:0] CREEP_MAX = 8'hc8;
  localparam logic [7:0] CREEP_RESET = 8'h1e;
  localparam logic [11:0] POINT_SPEED_MAX = 12'hfff;

  // offset arithmetic
  localparam logic signed [31:0] COARSE_SCALE = 32'sd10000;
  localparam logic signed [15:0] FIELD_MAX = 16'sd9999;
  localparam logic signed [15:0] FIELD_MIN = -16'sd9999;

  // dwell time unit
  localparam int DWELL_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DWELL_UNIT_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS;

  localparam int CTRL_W = 21;

  typedef struct packed {
    logic run_enable;
    logic [3:0] end_point;
    logic [3:0] start_point;
    logic stop_method_field;
    logic [1:0] error_clear_policy;
    logic [1:0] step_change_mode;
    logic [1:0] run_mode_field;
    logic distance_interpretation;
    logic [3:0] control_mode_select;
  } ptp_ctrl_type;

  typedef struct packed {
    logic signed [15:0] fine_offset_field;
    logic signed [15:0] coarse_offset_field;
    logic [11:0] speed;
    logic [15:0] reference_filter_time;
    logic [15:0] dwell;
  } ptp_point_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ptp_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptp_apb_rsp_type;

  typedef struct packed {
    logic signed [31:0] target_position;
    logic [11:0] speed_rpm;
    logic [15:0] reference_filter_time;
    logic velocity_mode;
    logic reverse_dir;
    logic stop_request;
    logic stop_method_field;
    logic motor_clamp;
    logic current_limit_enable;
    logic error_clear;
    logic coord_zero;
    logic [3:0] point_index;
  } ptp_drive_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WAIT_START = 4'b0001,
    ST_HOME_SEEK = 4'b0010,
    ST_HOME_STOP = 4'b0011,
    ST_HOME_BACK = 4'b0100,
    ST_HOME_INDEX = 4'b0101,
    ST_DWELL = 4'b0110,
    ST_WAIT_STEP = 4'b0111,
    ST_MOVE = 4'b1000,
    ST_SETTLE = 4'b1001,
    ST_PAUSE = 4'b1010,
    ST_DONE = 4'b1011
  } ptp_state_type;
endpackage

//--- hdl/ptp_positioner.sv
// point-table positioner with pulse inhibit and reference search
//
// Overview of operation
// - pulse inhibit stops reference pulses adding to the position command count
// - motor held clamped at present position while pulses are inhibited
// - mode switch low means inhibit on, high means inhibit off
// - control mode select value C runs the internal point table
// - sixteen points, each with distance, speed, filter time and dwell
// - point offset is coarse times 10000 plus fine, each field within +/-9999
// - point speed is the true motor speed, no gear scaling
// - point filter time used like the ordinary position reference filter
// - absolute or relative interpretation of distances selected by configuration
// - circling mode repeats the program, non-circling stops after end point
// - step to next point after delay or on mode switch activity
// - delay counted from positioning done, servo on or reference found
// - error clear policy: 0 servo off, 1 never, 2 servo off or overtravel
// - without servo-off clearing the error counter may overflow during a run
// - search goes toward the side whose limit input carries the home switch
// - on switch: stop, reverse off switch, zero at first index pulse after
// - approach at search speed, 0 to 3000 rpm, default 1500
// - leave switch at creep speed, 0 to 200 rpm, default 30
// - limit inputs not used for current limiting during search
// - run mode 0/1 cycle/single started forward, 2/3 started reverse
// - relative: travel from current point; absolute: from reference point
`timescale 1ns/1ps
`default_nettype none
module ptp_positioner #(
  parameter int DWELL_CYCLES = ptp_pkg::DWELL_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire ptp_pkg::ptp_apb_req_type apb_req,
  output ptp_pkg::ptp_apb_rsp_type apb_rsp,
  input wire logic ref_pulse,
  input wire logic ref_dir,
  input wire logic mode_switch_input_n,
  input wire logic forward_limit_input_n,
  input wire logic reverse_limit_input_n,
  input wire logic encoder_index,
  input wire logic servo_on,
  input wire logic overtravel,
  input wire logic motion_settled,
  output ptp_pkg::ptp_drive_type drive
);
  import ptp_pkg::*;

  typedef struct packed {
    ptp_ctrl_type ctrl;
    logic [11:0] search_speed;
    logic [7:0] creep_speed;
    ptp_point_type [15:0] pts;
    ptp_state_type st;
    logic [3:0] idx;
    logic homed;
    logic signed [31:0] pulse_count;
    logic signed [31:0] cur_pos;
    logic [31:0] tick;
    logic [15:0] units;
    logic prev_switch;
    logic prev_servo;
    ptp_apb_rsp_type rsp;
    ptp_drive_type drv;
  } ptp_regs_type;

  ptp_regs_type r;
  ptp_regs_type next_r;
  logic rst_meta;
  logic rst_n;

  function automatic logic signed [15:0] clamp_field(input logic [15:0] v);
    logic signed [15:0] s;
    s = signed'(v);
    if (s > FIELD_MAX) begin
      return FIELD_MAX;
    end else if (s < FIELD_MIN) begin
      return FIELD_MIN;
    end
    return s;
  endfunction

  function automatic logic [11:0] clamp_speed(input logic [11:0] v, input logic [11:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic signed [31:0] point_offset(input ptp_point_type p);
    logic signed [31:0] c;
    logic signed [31:0] f;
    c = 32'(p.coarse_offset_field);
    f = 32'(p.fine_offset_field);
    return c * COARSE_SCALE + f;
  endfunction

  // point table window decode, shared by read and write paths
  function automatic logic is_point_addr(input logic [11:0] a);
    return (a & ADDR_PT_MASK) == ADDR_PT_BASE;
  endfunction

  // where the sequencer waits before the next move
  function automatic ptp_state_type step_wait(input logic by_delay);
    return by_delay ? ST_DWELL : ST_WAIT_STEP;
  endfunction

  // active-low limit pin on the chosen side
  function automatic logic limit_active(input logic fwd_side, input logic fwd_n,
                                        input logic rev_n);
    return fwd_side ? !fwd_n : !rev_n;
  endfunction

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic point_mode;
  logic home_fwd;
  logic home_hit;
  logic start_hit;
  logic delay_step;
  logic switch_edge;
  logic servo_rise;
  logic single_run;
  ptp_point_type cur_pt;
  logic [31:0] rdata;
  logic rmapped;
  logic [3:0] pt_i;
  logic [1:0] pt_w;

  // mode, limit and read-mux decode
  always_comb begin
    point_mode = (r.ctrl.control_mode_select == CMODE_POINT);
    // modes 0/1 home on the reverse switch, 2/3 on the forward switch
    home_fwd = r.ctrl.run_mode_field[1];
    home_hit = limit_active(home_fwd, forward_limit_input_n, reverse_limit_input_n);
    start_hit = limit_active(!home_fwd, forward_limit_input_n, reverse_limit_input_n);
    single_run = r.ctrl.run_mode_field[0];
    delay_step = !r.ctrl.step_change_mode[0];
    switch_edge = (mode_switch_input_n != r.prev_switch);
    servo_rise = servo_on && !r.prev_servo;
    cur_pt = r.pts[r.idx];
    pt_i = apb_req.paddr[PT_IDX_LSB +: 4];
    pt_w = apb_req.paddr[PT_WORD_LSB +: 2];
    rmapped = 1'b1;
    rdata = '0;
    if (is_point_addr(apb_req.paddr)) begin
      unique case (pt_w)
        PT_WORD_OFFSET: rdata = {r.pts[pt_i].fine_offset_field, r.pts[pt_i].coarse_offset_field};
        PT_WORD_SPEED: rdata = 32'(r.pts[pt_i].speed);
        PT_WORD_FILTER: rdata = 32'(r.pts[pt_i].reference_filter_time);
        PT_WORD_DWELL: rdata = 32'(r.pts[pt_i].dwell);
      endcase
    end else begin
      unique case (apb_req.paddr)
        ADDR_CTRL: rdata = 32'(r.ctrl);
        ADDR_SPEED: rdata = {8'h00, r.creep_speed, 4'h0, r.search_speed};
        ADDR_STATUS: rdata = {16'h0000, r.homed, r.drv.motor_clamp, r.drv.error_clear,
                              1'b0, r.idx, 4'h0, r.st};
        ADDR_POS: rdata = r.drv.target_position;
        ADDR_PULSE: rdata = r.pulse_count;
        default: rmapped = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_r = r;
    // sampled every cycle so an old edge is never replayed
    next_r.prev_switch = mode_switch_input_n;
    next_r.prev_servo = servo_on;
    next_r.drv.coord_zero = 1'b0;
    next_r.drv.stop_request = 1'b0;
    next_r.drv.velocity_mode = 1'b0;
    next_r.drv.stop_method_field = r.ctrl.stop_method_field;

    // apb slave: one wait state, write lands on the pready edge
    next_r.rsp.pready = 1'b0;
    next_r.rsp.pslverr = 1'b0;
    if (apb_req.psel && apb_req.penable && !r.rsp.pready) begin
      next_r.rsp.pready = 1'b1;
      next_r.rsp.pslverr = !rmapped;
      next_r.rsp.prdata = apb_req.pwrite ? 32'h0000_0000 : rdata;
    end
    // write lands on the edge at which the master samples pready
    if (apb_req.psel && apb_req.penable && r.rsp.pready && apb_req.pwrite) begin
      if (is_point_addr(apb_req.paddr)) begin
        unique case (pt_w)
          PT_WORD_OFFSET: begin
            next_r.pts[pt_i].coarse_offset_field = clamp_field(apb_req.pwdata[15:0]);
            next_r.pts[pt_i].fine_offset_field = clamp_field(apb_req.pwdata[31:16]);
          end
          PT_WORD_SPEED: next_r.pts[pt_i].speed = apb_req.pwdata[11:0];
          PT_WORD_FILTER: next_r.pts[pt_i].reference_filter_time = apb_req.pwdata[15:0];
          PT_WORD_DWELL: next_r.pts[pt_i].dwell = apb_req.pwdata[15:0];
        endcase
      end else if (apb_req.paddr == ADDR_CTRL) begin
        next_r.ctrl = ptp_ctrl_type'(apb_req.pwdata[CTRL_W-1:0]);
      end else if (apb_req.paddr == ADDR_SPEED) begin
        next_r.search_speed = clamp_speed(apb_req.pwdata[11:0], SEARCH_MAX);
        next_r.creep_speed = 8'(clamp_speed(12'(apb_req.pwdata[SPEED_CREEP_LSB +: 8]),
                                            12'(CREEP_MAX)));
      end
    end

    // reference pulse counting with inhibit
    next_r.drv.motor_clamp = !point_mode && !mode_switch_input_n;
    if (!point_mode) begin
      if (ref_pulse && mode_switch_input_n) begin
        next_r.pulse_count = ref_dir ? r.pulse_count - 32'sd1 : r.pulse_count + 32'sd1;
      end
      next_r.drv.target_position = r.pulse_count;
    end

    // error counter clear policy; policy 1 lets the counter run on
    unique case (r.ctrl.error_clear_policy)
      ECLR_SERVO_OFF: next_r.drv.error_clear = !servo_on;
      ECLR_BOTH: next_r.drv.error_clear = !servo_on || overtravel;
      default: next_r.drv.error_clear = 1'b0;
    endcase

    next_r.drv.current_limit_enable = 1'b1;

    // point table sequencer
    if (!point_mode || !r.ctrl.run_enable) begin
      next_r.st = ST_IDLE;
    end else begin
      unique case (r.st)
        // a fresh run always homes first
        ST_IDLE: begin
          if (servo_on) begin
            next_r.homed = 1'b0;
            next_r.st = r.ctrl.step_change_mode[1] ? ST_WAIT_START : ST_HOME_SEEK;
          end
        end

        // hold until the start input is seen
        ST_WAIT_START: begin
          if (start_hit) begin
            next_r.st = ST_HOME_SEEK;
          end
        end

        // toward the home switch at search speed
        ST_HOME_SEEK: begin
          next_r.drv.current_limit_enable = 1'b0;
          next_r.drv.velocity_mode = 1'b1;
          next_r.drv.reverse_dir = !home_fwd;
          next_r.drv.speed_rpm = r.search_speed;
          if (home_hit) begin
            next_r.st = ST_HOME_STOP;
          end
        end

        // let the motor stand before turning
        ST_HOME_STOP: begin
          next_r.drv.current_limit_enable = 1'b0;
          next_r.drv.stop_request = 1'b1;
          if (motion_settled) begin
            next_r.st = ST_HOME_BACK;
          end
        end

        // creep off the switch, zero on the next index
        ST_HOME_BACK, ST_HOME_INDEX: begin
          next_r.drv.current_limit_enable = 1'b0;
          next_r.drv.velocity_mode = 1'b1;
          next_r.drv.reverse_dir = home_fwd;
          next_r.drv.speed_rpm = 12'(r.creep_speed);
          if (r.st == ST_HOME_BACK && !home_hit) begin
            next_r.st = ST_HOME_INDEX;
          end
          if (r.st == ST_HOME_INDEX && encoder_index) begin
            next_r.drv.velocity_mode = 1'b0;
            next_r.drv.coord_zero = 1'b1;
            next_r.homed = 1'b1;
            next_r.cur_pos = '0;
            next_r.drv.target_position = '0;
            next_r.idx = r.ctrl.start_point;
            next_r.units = r.pts[r.ctrl.start_point].dwell;
            next_r.tick = '0;
            next_r.st = step_wait(delay_step);
          end
        end

        // dwell counted in whole units
        ST_DWELL: begin
          if (!servo_on) begin
            next_r.st = ST_PAUSE;
          end else if (r.units == 16'h0000) begin
            next_r.st = ST_MOVE;
          end else if (r.tick == 32'(DWELL_CYCLES - 1)) begin
            next_r.tick = '0;
            next_r.units = r.units - 16'h0001;
          end else begin
            next_r.tick = r.tick + 32'h0000_0001;
          end
        end

        // any level change of the switch steps
        ST_WAIT_STEP: begin
          if (!servo_on) begin
            next_r.st = ST_PAUSE;
          end else if (switch_edge) begin
            next_r.st = ST_MOVE;
          end
        end

        // absolute from zero, relative from last target
        ST_MOVE: begin
          if (r.ctrl.distance_interpretation) begin
            next_r.drv.target_position = point_offset(cur_pt);
          end else begin
            next_r.drv.target_position = r.cur_pos + point_offset(cur_pt);
          end
          next_r.drv.speed_rpm = clamp_speed(cur_pt.speed, POINT_SPEED_MAX);
          next_r.drv.reference_filter_time = cur_pt.reference_filter_time;
          next_r.drv.point_index = r.idx;
          next_r.st = ST_SETTLE;
        end

        // wait for positioning done, then pick next point
        ST_SETTLE: begin
          if (!servo_on) begin
            next_r.st = ST_PAUSE;
          end else if (motion_settled) begin
            next_r.cur_pos = r.drv.target_position;
            next_r.units = cur_pt.dwell;
            next_r.tick = '0;
            if (r.idx == r.ctrl.end_point) begin
              next_r.idx = r.ctrl.start_point;
              next_r.st = single_run ? ST_DONE : step_wait(delay_step);
            end else begin
              next_r.idx = r.idx + 4'h1;
              next_r.st = step_wait(delay_step);
            end
          end
        end

        // servo off holds; servo on restarts the dwell
        ST_PAUSE: begin
          if (servo_rise) begin
            next_r.units = cur_pt.dwell;
            next_r.tick = '0;
            next_r.st = step_wait(delay_step);
          end
        end

        // single run parks until run enable drops
        ST_DONE: begin
          next_r.st = ST_DONE;
        end
        default: next_r.st = ST_IDLE;
      endcase
    end
  end

  // one register stage holds all state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.search_speed <= SEARCH_RESET;
      r.creep_speed <= CREEP_RESET;
      r.prev_switch <= 1'b1;
      r.drv.current_limit_enable <= 1'b1;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state register
  assign apb_rsp = r.rsp;
  assign drive = r.drv;
endmodule // ptp_positioner
`default_nettype wire
